//--- logic/seven_channel_dma.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module seven_channel_dma
   import dma_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output mem_req_t memReq,
   input wire logic [7:0] memRdData,
   input wire logic [7:0] xferReq,
   input wire logic [7:0] periphRdData,
   output transfer_function_field_op_t periphOp,
   input wire logic cpuBusy,
   input wire logic cpuDebug,
   input wire logic sleepMode,
   output logic sleepReady,
   output logic irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [2:0] sel_q, sel_d; // selected channel
   // RL1: seven copies of channel state
   logic [7:0] cfg_q [NUM_CH]; // per-channel config
   logic [7:0] cfg_d [NUM_CH];
   // RL7: base, offset and size widths
   logic [BASE_W-1:0] base_q [NUM_CH]; // memory base
   logic [BASE_W-1:0] base_d [NUM_CH];
   logic [OFS_W-1:0] ofs_q [NUM_CH]; // offset counter
   logic [OFS_W-1:0] ofs_d [NUM_CH];
   logic [OFS_W-1:0] size_q [NUM_CH]; // byte count
   logic [OFS_W-1:0] size_d [NUM_CH];
   logic [6:0] wrap_q, wrap_d; // wrap mode per channel
   logic [6:0] en_q, en_d; // channel enables
   logic [6:0] intFlag_q, intFlag_d; // full-length flags
   logic [6:0] midFlag_q, midFlag_d; // midpoint flags
   logic [6:0] busy_q, busy_d; // transfer in progress
   logic [6:0] force_q, force_d; // software forced starts
   state_t state_q, state_d; // engine state
   logic [2:0] cur_q, cur_d; // granted channel
   logic idx_q, idx_d; // byte index in transaction
   logic [2:0] issueFunc_q, issueFunc_d; // function of read in flight
   logic issueLane_q, issueLane_d; // lane of read in flight
   logic [7:0] regRdData_q, regRdData_d;
   mem_req_t memReq_q, memReq_d;
   transfer_function_field_op_t periphOp_q, periphOp_d;
   logic sleepReady_q, sleepReady_d;
   logic irq_q, irq_d;
   // ---------------------------------------------------------------
   // current channel view
   // ---------------------------------------------------------------
   logic [7:0] curCfg; // config of granted channel
   logic [2:0] curFunc; // its transfer function
   logic toMem; // register to memory path
   logic twoByte; // 16-bit transaction
   logic curLane; // peripheral byte lane
   logic [OFS_W-1:0] curOfs; // its offset
   logic [OFS_W-1:0] curSize; // its size
   logic [OFS_W-1:0] midPoint; // half size, odd rounds up
   logic [BASE_W-1:0] effAddr; // effective memory address
   logic lastByte; // offset at size minus one
   logic midHit; // offset at midpoint
   logic haltNow; // cpu, debug or sleep holds engine
   logic moveNow; // a byte moves this cycle
   logic [6:0] eligible; // channels ready for grant
   logic [2:0] grantCh; // lowest eligible channel
   logic found; // any eligible channel
   // the granted channel's settings
   always_comb begin
      curCfg = cfg_q[cur_q];
      // RL3: function path
      curFunc = curCfg[2:0];
      toMem = FN_TO_MEM_MASK[curFunc];
      twoByte = FN_TWO_BYTE_MASK[curFunc];
      // RL4: byte order
      curLane = idx_q ^ (curCfg[CFG_ENDIAN] & twoByte);
      curOfs = ofs_q[cur_q];
      curSize = size_q[cur_q];
      midPoint = (curSize >> 1) + {9'h000, curSize[0]};
      // RL8: base plus offset
      effAddr = BASE_W'(base_q[cur_q] + {2'h0, curOfs});
      // RL10: end of length
      lastByte = (curOfs == curSize - 10'h001);
      // RL11: midpoint compare
      midHit = (curOfs == midPoint);
   end
   // RL19: cpu first; RL22: debug halt; RL21: no work in sleep
   assign haltNow = cpuBusy | cpuDebug | sleepMode;
   // no read-ack while a register write of the pipe is pending
   assign moveNow = (state_q == ST_RUN) && en_q[cur_q] && !haltNow && !(toMem && memReq_q.rd);
   // channel eligibility and fixed priority pick
   always_comb begin
      eligible = '0;
      grantCh = 3'h0;
      found = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         // RL14: enable; RL5: stall; RL12: flags block; RL16/RL17: request or force
         eligible[c] = en_q[c] && !cfg_q[c][CFG_STALL] && !intFlag_q[c] &&
                       !midFlag_q[c] && (xferReq[cfg_q[c][2:0]] || force_q[c]);
      end
      // RL20: lowest number wins
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (eligible[c]) begin
            grantCh = 3'(c);
            found = 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      sel_d = sel_q;
      cfg_d = cfg_q;
      base_d = base_q;
      ofs_d = ofs_q;
      size_d = size_q;
      wrap_d = wrap_q;
      en_d = en_q;
      intFlag_d = intFlag_q;
      midFlag_d = midFlag_q;
      busy_d = busy_q;
      force_d = force_q;
      state_d = state_q;
      cur_d = cur_q;
      idx_d = idx_q;
      issueFunc_d = issueFunc_q;
      issueLane_d = issueLane_q;
      regRdData_d = 8'h00;
      memReq_d = '0;
      periphOp_d = periphOp_q;
      periphOp_d.wr = 1'b0;
      periphOp_d.rdAck = 1'b0;
      // register reads, data stands one cycle
      if (regRd) begin
         if (regAddr == REG_SEL) begin
            regRdData_d = {5'h00, sel_q};
         end else if (regAddr == REG_CFG) begin
            regRdData_d = cfg_q[sel_q];
         end else if (regAddr == REG_MODE) begin
            regRdData_d = {7'h00, wrap_q[sel_q]};
         end else if (regAddr == REG_BASE_L) begin
            regRdData_d = base_q[sel_q][7:0];
         end else if (regAddr == REG_BASE_H) begin
            regRdData_d = {4'h0, base_q[sel_q][11:8]};
         end else if (regAddr == REG_OFS_L) begin
            regRdData_d = ofs_q[sel_q][7:0];
         end else if (regAddr == REG_OFS_H) begin
            regRdData_d = {6'h00, ofs_q[sel_q][9:8]};
         end else if (regAddr == REG_SIZE_L) begin
            regRdData_d = size_q[sel_q][7:0];
         end else if (regAddr == REG_SIZE_H) begin
            regRdData_d = {6'h00, size_q[sel_q][9:8]};
         end else if (regAddr == REG_EN) begin
            regRdData_d = {1'b0, en_q};
         end else if (regAddr == REG_INT) begin
            regRdData_d = {1'b0, intFlag_q};
         end else if (regAddr == REG_MINT) begin
            regRdData_d = {1'b0, midFlag_q};
         end else if (regAddr == REG_BUSY) begin
            regRdData_d = {1'b0, busy_q};
         end
      end
      // register writes
      if (regWr) begin
         // RL2: select only real channels
         if (regAddr == REG_SEL) begin
            if (regWrData[2:0] != 3'h7) begin
               sel_d = regWrData[2:0];
            end
         end else if (regAddr == REG_CFG) begin
            cfg_d[sel_q] = regWrData;
         end else if (regAddr == REG_MODE) begin
            wrap_d[sel_q] = regWrData[0];
         // RL15: address settings locked while busy
         end else if (regAddr == REG_BASE_L && !busy_q[sel_q]) begin
            base_d[sel_q][7:0] = regWrData;
         end else if (regAddr == REG_BASE_H && !busy_q[sel_q]) begin
            base_d[sel_q][11:8] = regWrData[3:0];
         end else if (regAddr == REG_OFS_L && !busy_q[sel_q]) begin
            ofs_d[sel_q][7:0] = regWrData;
         end else if (regAddr == REG_OFS_H && !busy_q[sel_q]) begin
            ofs_d[sel_q][9:8] = regWrData[1:0];
         end else if (regAddr == REG_SIZE_L && !busy_q[sel_q]) begin
            size_d[sel_q][7:0] = regWrData;
         end else if (regAddr == REG_SIZE_H && !busy_q[sel_q]) begin
            size_d[sel_q][9:8] = regWrData[1:0];
         end else if (regAddr == REG_EN) begin
            en_d = regWrData[6:0];
         // RL12: software clears flags by writing zero
         end else if (regAddr == REG_INT) begin
            intFlag_d = intFlag_q & regWrData[6:0];
         end else if (regAddr == REG_MINT) begin
            midFlag_d = midFlag_q & regWrData[6:0];
         // RL17: one forces a start, zero is ignored
         end else if (regAddr == REG_BUSY) begin
            force_d = force_q | regWrData[6:0];
         end
      end
      // RL13: second stage of a memory read writes the register
      if (memReq_q.rd) begin
         periphOp_d.wr = 1'b1;
         periphOp_d.data = memRdData;
         periphOp_d.func = issueFunc_q;
         periphOp_d.lane = issueLane_q;
      end
      // engine
      case (state_q)
         ST_IDLE: begin
            // RL20: grant only between transactions
            if (found && !haltNow) begin
               state_d = ST_RUN;
               cur_d = grantCh;
               // RL15: busy for the transaction
               busy_d[grantCh] = 1'b1;
               force_d[grantCh] = 1'b0;
               idx_d = 1'b0;
            end
         end
         ST_RUN: begin
            // RL14: disabled channel ends at once
            if (!en_q[cur_q]) begin
               state_d = ST_IDLE;
               busy_d[cur_q] = 1'b0;
            end else if (moveNow) begin
               memReq_d.addr = effAddr;
               if (toMem) begin
                  // RL13: one cycle per byte to memory
                  memReq_d.wr = 1'b1;
                  memReq_d.data = periphRdData;
                  periphOp_d.rdAck = 1'b1;
                  periphOp_d.func = curFunc;
                  periphOp_d.lane = curLane;
               end else begin
                  memReq_d.rd = 1'b1;
                  issueFunc_d = curFunc;
                  issueLane_d = curLane;
               end
               // RL8: offset counts bytes
               if (lastByte) begin
                  // RL10: full-length flag, set beats clear
                  intFlag_d[cur_q] = 1'b1;
                  if (wrap_q[cur_q]) begin
                     // RL18: wrap to zero
                     ofs_d[cur_q] = 10'h000;
                  end else begin
                     en_d[cur_q] = 1'b0;
                  end
               end else begin
                  ofs_d[cur_q] = curOfs + 10'h001;
               end
               // RL11: midpoint flag, set beats clear
               if (midHit) begin
                  midFlag_d[cur_q] = 1'b1;
               end
               idx_d = ~idx_q;
               // RL20: boundary every byte, or every two bytes
               if (lastByte || idx_q == twoByte) begin
                  state_d = ST_IDLE;
                  busy_d[cur_q] = 1'b0;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // RL21: sleep may enter once nothing is pending
      sleepReady_d = (state_d == ST_IDLE) && (busy_d == 7'h00) && !found && !memReq_d.rd;
      irq_d = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         // RL24/RL25/RL26: enabled flags raise the request
         irq_d = irq_d | (intFlag_d[c] & cfg_d[c][CFG_FULL_IE]) |
                 (midFlag_d[c] & cfg_d[c][CFG_MID_IE]);
      end
   end
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_q <= 3'h0;
         for (int c = 0; c < NUM_CH; c++) begin
            cfg_q[c] <= CFG_RST;
            base_q[c] <= 12'h000;
            ofs_q[c] <= 10'h000;
            size_q[c] <= 10'h000;
         end
         wrap_q <= CH_VEC_RST;
         en_q <= CH_VEC_RST;
         intFlag_q <= CH_VEC_RST;
         midFlag_q <= CH_VEC_RST;
         busy_q <= CH_VEC_RST;
         force_q <= CH_VEC_RST;
         state_q <= ST_IDLE;
         cur_q <= 3'h0;
         idx_q <= 1'b0;
         issueFunc_q <= 3'h0;
         issueLane_q <= 1'b0;
         regRdData_q <= 8'h00;
         memReq_q <= '0;
         periphOp_q <= '0;
         sleepReady_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
         cfg_q <= cfg_d;
         base_q <= base_d;
         ofs_q <= ofs_d;
         size_q <= size_d;
         wrap_q <= wrap_d;
         en_q <= en_d;
         intFlag_q <= intFlag_d;
         midFlag_q <= midFlag_d;
         busy_q <= busy_d;
         force_q <= force_d;
         state_q <= state_d;
         cur_q <= cur_d;
         idx_q <= idx_d;
         issueFunc_q <= issueFunc_d;
         issueLane_q <= issueLane_d;
         regRdData_q <= regRdData_d;
         memReq_q <= memReq_d;
         periphOp_q <= periphOp_d;
         sleepReady_q <= sleepReady_d;
         irq_q <= irq_d;
      end
   end
   // outputs straight from flops
   assign regRdData = regRdData_q;
   assign memReq = memReq_q;
   assign periphOp = periphOp_q;
   assign sleepReady = sleepReady_q;
   assign irq = irq_q;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic grantNow; // helper: grant taken this cycle
   logic [BASE_W-1:0] selBase; // helper: selected base
   assign grantNow = (state_q == ST_IDLE) && found && !haltNow;
   assign selBase = base_q[sel_q];
   property p_one_busy;
      $onehot0(busy_q);
   endproperty
   a_one_busy: assert property (p_one_busy) else $error("two channels busy"); // RL1
   property p_priority;
      grantNow |-> ((eligible & ((7'h01 << grantCh) - 7'h01)) == 7'h00);
   endproperty
   a_priority: assert property (p_priority) else $error("lower channel skipped"); // RL20
   property p_cpu_wins;
      cpuBusy |=> !memReq_q.rd && !memReq_q.wr;
   endproperty
   a_cpu_wins: assert property (p_cpu_wins) else $error("engine beat cpu"); // RL19
   property p_debug_halt;
      cpuDebug [*2] |=> !memReq_q.rd && !memReq_q.wr && !periphOp_q.wr;
   endproperty
   a_debug_halt: assert property (p_debug_halt) else $error("moved in debug"); // RL22
   property p_rd_pipe;
      memReq_q.rd |=> periphOp_q.wr && periphOp_q.data == $past(memRdData);
   endproperty
   a_rd_pipe: assert property (p_rd_pipe) else $error("register write missing"); // RL13
   property p_addr;
      moveNow |=> memReq_q.addr == $past(effAddr);
   endproperty
   a_addr: assert property (p_addr) else $error("bad effective address"); // RL8
   property p_ofs_inc;
      (moveNow && !lastByte) |=> ofs_q[cur_q] == $past(curOfs) + 10'h001;
   endproperty
   a_ofs_inc: assert property (p_ofs_inc) else $error("offset not advanced"); // RL8
   property p_full;
      (moveNow && lastByte) |=> intFlag_q[$past(cur_q)];
   endproperty
   a_full: assert property (p_full) else $error("full flag not set"); // RL10
   property p_mid;
      (moveNow && midHit) |=> midFlag_q[$past(cur_q)];
   endproperty
   a_mid: assert property (p_mid) else $error("midpoint flag not set"); // RL11
   property p_stall;
      grantNow |-> !cfg_q[grantCh][CFG_STALL] && !intFlag_q[grantCh] &&
                   !midFlag_q[grantCh];
   endproperty
   a_stall: assert property (p_stall) else $error("blocked channel granted"); // RL5
   property p_lock;
      (regWr && regAddr == REG_BASE_L && busy_q[sel_q]) |=> $stable(selBase);
   endproperty
   a_lock: assert property (p_lock) else $error("base written while busy"); // RL15
   c_wrap: cover property (moveNow && lastByte && wrap_q[cur_q]);
   c_force: cover property (grantNow && force_q[grantCh] && !xferReq[cfg_q[grantCh][2:0]]);
   c_pipe: cover property (memReq_q.rd [*2]);
   c_conflict: cover property (grantNow && !$onehot(eligible));
endmodule
`default_nettype wire

//--- logic/dma_pkg.sv
// Operation
// RL1: seven independent channels share common control
// RL2: 3-bit select steers per-channel register accesses
// RL3: 3-bit function field picks the data path
// RL4: config holds byte order, stall, interrupt enables
// RL5: stall finishes current transfer, blocks new ones
// RL6: software polls busy after setting stall
// RL7: 12-bit base, 10-bit offset, 10-bit size
// RL8: address is base plus offset; offset increments
// RL9: software zeroes offset, keeps it below size
// RL10: offset at size minus one sets full flag
// RL11: midpoint flag at half size, odd rounds up
// RL12: flags stay set and block next transfer
// RL13: memory-to-register two cycles pipelined; reverse one
// RL14: channel moves data only while enabled
// RL15: busy while transferring; address writes then ignored
// RL16: peripherals raise their own transfer requests
// RL17: writing busy one forces a transfer start
// RL18: wrap returns offset to zero, keeps going
// RL19: cpu access wins, engine waits
// RL20: lowest channel wins at transaction boundaries only
// RL21: halted in sleep; sleep waits for pending work
// RL22: all transfers halt in cpu debug
// RL23: software configures select, config, wrap, base, size
// RL24: config bit 7 enables full-length interrupt
// RL25: config bit 6 enables midpoint interrupt
// RL26: interrupt request while enabled flag is set
`default_nettype none
package dma_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_CH = 7;
   localparam int BASE_W = 12;
   localparam int OFS_W = 10;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_SEL = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h01;
   localparam logic [7:0] REG_MODE = 8'h02;
   localparam logic [7:0] REG_BASE_L = 8'h03;
   localparam logic [7:0] REG_BASE_H = 8'h04;
   localparam logic [7:0] REG_OFS_L = 8'h05;
   localparam logic [7:0] REG_OFS_H = 8'h06;
   localparam logic [7:0] REG_SIZE_L = 8'h07;
   localparam logic [7:0] REG_SIZE_H = 8'h08;
   localparam logic [7:0] REG_EN = 8'h09;
   localparam logic [7:0] REG_INT = 8'h0A;
   localparam logic [7:0] REG_MINT = 8'h0B;
   localparam logic [7:0] REG_BUSY = 8'h0C;
   // ---------------------------------------------------------------
   // config fields and reset values
   // ---------------------------------------------------------------
   localparam int CFG_ENDIAN = 3;
   localparam int CFG_STALL = 5;
   localparam int CFG_MID_IE = 6;
   localparam int CFG_FULL_IE = 7;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [6:0] CH_VEC_RST = 7'h00;
   // functions whose data flows register to memory (1 and 4)
   localparam logic [7:0] FN_TO_MEM_MASK = 8'h12;
   // functions moving two bytes per transaction (encoder, 0 and 1)
   localparam logic [7:0] FN_TWO_BYTE_MASK = 8'h03;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} state_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [BASE_W-1:0] addr;
      logic [7:0] data;
   } mem_req_t;
   typedef struct packed {
      logic wr;
      logic rdAck;
      logic [2:0] func;
      logic lane;
      logic [7:0] data;
   } transfer_function_field_op_t;
endpackage
`default_nettype wire

//--- tb/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// memory and peripheral stand-in
// ---------------------------------------------------------------
module far_side_model
   import dma_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire mem_req_t memReq,
   input wire transfer_function_field_op_t periphOp,
   input wire logic [7:0] reqMask,
   output logic [7:0] memRdData,
   output logic [7:0] xferReq,
   output logic [7:0] periphRdData
);
   logic [7:0] lastRd_q; // last byte put on the read bus
   logic [7:0] taken_q; // bytes taken from the peripheral so far
   assign xferReq = reqMask;
   // data only while rd is high, otherwise toggling junk
   assign memRdData = memReq.rd ? (memReq.addr[7:0] ^ 8'h5A) : ~lastRd_q;
   // each byte taken exposes the next pattern value
   assign periphRdData = 8'hC0 + taken_q;
   // track bus value and consumed bytes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lastRd_q <= 8'h00;
         taken_q <= 8'h00;
      end else begin
         lastRd_q <= memRdData;
         if (periphOp.rdAck) begin
            taken_q <= taken_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/seven_channel_dma_bench.sv
`timescale 1ns/1ps
`default_nettype none
module seven_channel_dma_bench
   import dma_pkg::*;
;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic clk, rst, regWr, regRd, cpuBusy, cpuDebug, sleepMode, sleepReady, irq;
   logic [7:0] regAddr, regWrData, regRdData, memRdData, xferReq, periphRdData, reqMask;
   mem_req_t memReq;
   transfer_function_field_op_t periphOp;
   mem_req_t ops[$]; // memory requests seen
   transfer_function_field_op_t wrs[$]; // register writes seen
   logic [7:0] lastRd = 8'h00; // read byte of the previous cycle
   logic prevRd = 1'b0; // rd strobe of the previous cycle
   int numErrors = 0;
   int checked = 0;
   // write, read back, expected
   row_t rows[8] = '{'{REG_SEL, 8'h03, 8'h03}, '{REG_SEL, 8'h07, 8'h03},
      '{REG_CFG, 8'hEA, 8'hEA}, '{REG_MODE, 8'h01, 8'h01}, '{REG_BASE_L, 8'h34, 8'h34},
      '{REG_BASE_H, 8'h0F, 8'h0F}, '{REG_OFS_L, 8'h55, 8'h55}, '{8'h20, 8'hFF, 8'h00}};
   seven_channel_dma u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memReq(memReq),
      .memRdData(memRdData), .xferReq(xferReq), .periphRdData(periphRdData),
      .periphOp(periphOp), .cpuBusy(cpuBusy), .cpuDebug(cpuDebug),
      .sleepMode(sleepMode), .sleepReady(sleepReady), .irq(irq));
   far_side_model u_far (.clk(clk), .rst(rst), .memReq(memReq), .periphOp(periphOp),
      .reqMask(reqMask), .memRdData(memRdData), .xferReq(xferReq),
      .periphRdData(periphRdData));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chkB(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         numErrors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkA(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         numErrors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // read strobe, then sample the one cycle of data
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chkB(regRdData, exp);
   endtask
   // bounded wait for n memory requests
   task automatic waitOps(input int n);
      for (int i = 0; i < 300 && ops.size() < n; i++) begin
         @(posedge clk);
      end
      chkB(8'(ops.size()), 8'(n));
   endtask
   task automatic cfgCh(input logic [7:0] ch, cfg, mode, input logic [11:0] base,
      input logic [7:0] size);
      wr(REG_SEL, ch);
      wr(REG_CFG, cfg);
      wr(REG_MODE, mode);
      wr(REG_BASE_L, base[7:0]);
      wr(REG_BASE_H, {4'h0, base[11:8]});
      wr(REG_SIZE_L, size);
      wr(REG_SIZE_H, 8'h00);
      wr(REG_OFS_L, 8'h00);
      wr(REG_OFS_H, 8'h00);
   endtask
   task automatic wrap_up;
      if (numErrors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // clock, monitor, watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // record requests, check register writes follow reads
   always @(posedge clk) begin
      if (memReq.rd || memReq.wr) begin
         ops.push_back(memReq);
      end
      if (periphOp.wr) begin
         wrs.push_back(periphOp);
         chkB(periphOp.data, lastRd);
         chkB(8'(prevRd), 8'h01);
      end
      lastRd <= memRdData;
      prevRd <= memReq.rd;
   end
   initial begin
      repeat (20000) @(posedge clk);
      numErrors++;
      wrap_up;
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {regWr, regRd, cpuBusy, cpuDebug, sleepMode} = 5'h00;
      {regAddr, regWrData, reqMask} = 24'h00_0000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 8'h09; i < 8'h0D; i++) rdc(8'(i), 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].e);
      end
      wr(REG_SEL, 8'h04);
      rdc(REG_CFG, 8'h00);
      // memory to crc, midpoint then full stop
      cfgCh(8'h00, 8'hC2, 8'h00, 12'h120, 8'h04);
      wr(REG_EN, 8'h01);
      reqMask <= 8'h04;
      waitOps(3);
      repeat (20) @(posedge clk);
      chkB(8'(ops.size()), 8'h03);
      chkB(8'(irq), 8'h01);
      rdc(REG_MINT, 8'h01);
      wr(REG_MINT, 8'h00);
      waitOps(4);
      for (int i = 0; i < 4; i++) chkA(ops[i].addr, 12'h120 + 12'(i));
      rdc(REG_INT, 8'h01);
      rdc(REG_EN, 8'h00);
      chkB(8'(irq), 8'h01);
      reqMask <= 8'h00;
      wr(REG_INT, 8'h00);
      repeat (2) @(posedge clk);
      chkB(8'(irq), 8'h00);
      chkB(8'(sleepReady), 8'h01);
      // serial to memory with wrap, enables off
      ops.delete();
      cfgCh(8'h01, 8'h04, 8'h01, 12'h200, 8'h02);
      wr(REG_EN, 8'h02);
      reqMask <= 8'h10;
      waitOps(2);
      repeat (20) @(posedge clk);
      chkB(8'(ops.size()), 8'h02);
      for (int i = 0; i < 2; i++) chkA(ops[i].addr, 12'h200 + 12'(i));
      for (int i = 0; i < 2; i++) chkB(ops[i].data, 8'hC0 + 8'(i));
      rdc(REG_INT, 8'h02);
      rdc(REG_MINT, 8'h02);
      chkB(8'(irq), 8'h00);
      wr(REG_INT, 8'h00);
      wr(REG_MINT, 8'h00);
      waitOps(3);
      reqMask <= 8'h00;
      wr(REG_EN, 8'h00);
      chkA(ops[2].addr, 12'h200);
      chkB(ops[2].data, 8'hC2);
      wr(REG_INT, 8'h00);
      wr(REG_MINT, 8'h00);
      // forced start held off by debug, then released
      ops.delete();
      cfgCh(8'h02, 8'h05, 8'h00, 12'h300, 8'h08);
      wr(REG_EN, 8'h04);
      cpuDebug <= 1'b1;
      wr(REG_BUSY, 8'h04);
      repeat (20) @(posedge clk);
      chkB(8'(ops.size()), 8'h00);
      cpuDebug <= 1'b0;
      waitOps(1);
      chkA(ops[0].addr, 12'h300);
      // forced start held off by cpu access, then by sleep
      cpuBusy <= 1'b1;
      wr(REG_BUSY, 8'h04);
      repeat (10) @(posedge clk);
      chkB(8'(sleepReady), 8'h00);
      {cpuBusy, sleepMode} <= 2'b01;
      repeat (10) @(posedge clk);
      chkB(8'(ops.size()), 8'h01);
      sleepMode <= 1'b0;
      waitOps(2);
      chkA(ops[1].addr, 12'h301);
      wr(REG_CFG, 8'h25);
      wr(REG_BUSY, 8'h04);
      repeat (20) @(posedge clk);
      chkB(8'(ops.size()), 8'h02);
      rdc(REG_BUSY, 8'h00);
      // two-byte encoder feed, swapped lanes
      ops.delete();
      wrs.delete();
      cfgCh(8'h03, 8'h08, 8'h00, 12'h040, 8'h02);
      wr(REG_EN, 8'h08);
      reqMask <= 8'h01;
      waitOps(2);
      repeat (4) @(posedge clk);
      chkA(ops[1].addr, 12'h041);
      chkB(8'(wrs.size()), 8'h02);
      chkB({5'h00, wrs[0].func}, 8'h00);
      chkB({7'h00, wrs[0].lane}, 8'h01);
      chkB({7'h00, wrs[1].lane}, 8'h00);
      wrap_up;
   end
endmodule
`default_nettype wire
